// ---- can_init_pkg.sv ----
// Constants, field layout and mode type of the CAN start-up and interrupt block
package can_init_pkg;
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  MCR_OFS        = 8'h00;
   localparam logic [7:0]  CTRL_OFS       = 8'h04;
   localparam logic [7:0]  BUFFER_INTERRUPT_MASK_OFS      = 8'h08;
   localparam logic [7:0]  BUFFER_INTERRUPT_FLAGS_OFS      = 8'h0C;
   localparam logic [7:0]  ESTAT_OFS      = 8'h10;
   localparam logic [7:0]  GMASK_OFS      = 8'h14;
   localparam logic [7:0]  M14_OFS        = 8'h18;
   localparam logic [7:0]  M15_OFS        = 8'h1C;
   localparam logic [1:0]  MB_PAGE        = 2'h2;
   // module_config_reg fields
   localparam int          MCR_DIS_BIT    = 31;
   localparam int          MCR_FRZ_BIT    = 30;
   localparam int          MCR_HOLD_BIT   = 28;
   localparam int          MCR_NRDY_BIT   = 27;
   localparam int          MCR_SRST_BIT   = 25;
   localparam int          MCR_FACK_BIT   = 24;
   // protocol_control_reg fields
   localparam int          CTRL_PRES_LSB  = 24;
   localparam int          CTRL_BOFF_MSK  = 15;
   localparam int          CTRL_ERR_MSK   = 14;
   localparam int          CTRL_CSRC_BIT  = 13;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
   // error_status_reg fields
   localparam int          ESTAT_BOFF_BIT = 2;
   localparam int          ESTAT_ERR_BIT  = 1;
   // Handshake stages and recessive quanta needed for bus sync
   localparam int          SRST_MIN_CYC   = 5;
   localparam logic [3:0]  SYNC_QUANTA    = 4'hB;
   typedef enum logic [1:0] {
      MODE_DISABLED = 2'b00,
      MODE_FREEZE   = 2'b01,
      MODE_SYNCING  = 2'b11,
      MODE_ACTIVE   = 2'b10
   } mode_t;
endpackage

// ---- can_init_reset_irq.sv ----
// Reset, freeze start-up, soft-reset handshake and interrupt outputs of the CAN controller
`timescale 1ns/1ps
`default_nettype none
module can_init_reset_irq #(
   parameter int NUM_MB = 16
) (
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic [7:0]        addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   output logic [31:0]            rdata,
   input  wire logic              dev_soft_reset,
   input  wire logic              xtal_clk_pin,
   input  wire logic              bus_receive_pin,
   input  wire logic              engine_tx,
   input  wire logic [NUM_MB-1:0] mb_event,
   input  wire logic              bus_off_event,
   input  wire logic              error_event,
   output logic                   bus_transmit_pin,
   output logic                   frame_enable,
   output logic                   quantum_tick,
   output logic                   clock_source_select,
   output logic [NUM_MB-1:0]      mb_irq,
   output logic                   mb_irq_any,
   output logic                   bus_off_irq,
   output logic                   error_irq
);
   can_init_pkg::mode_t mode_q;
   logic              dis_q, frz_q, hold_q;
   logic [31:0]       ctrl_q, gmask_q, m14_q, m15_q;
   logic [NUM_MB-1:0] buffer_interrupt_mask_q, buffer_interrupt_flags_q;
   logic              boff_flag_q, err_flag_q;
   logic              srst_pend_q, srst_req_q, p_s1_q, p_s2_q, a_s1_q, a_s2_q;
   logic              srst_fire;
   logic              x_s1_q, x_s2_q, x_s3_q, rx_s1_q, rx_s2_q;
   logic [7:0]        pres_cnt_q;
   logic [3:0]        sync_cnt_q;
   logic [31:0]       mb_q [NUM_MB];
   logic              wr_mcr, wr_ctrl, src_tick, tq;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   assign wr_mcr  = wr_stb && hit(addr, can_init_pkg::MCR_OFS);
   assign wr_ctrl = wr_stb && hit(addr, can_init_pkg::CTRL_OFS);

   // Pin synchronisers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         x_s1_q  <= 1'b0;
         x_s2_q  <= 1'b0;
         x_s3_q  <= 1'b0;
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
      end else begin
         x_s1_q  <= xtal_clk_pin;
         x_s2_q  <= x_s1_q;
         x_s3_q  <= x_s2_q;
         rx_s1_q <= bus_receive_pin;
         rx_s2_q <= rx_s1_q;
      end
   end

   // Protocol clock source and quantum prescaler
   assign clock_source_select = ctrl_q[can_init_pkg::CTRL_CSRC_BIT];
   assign src_tick = clock_source_select ? (x_s2_q && !x_s3_q) : 1'b1;
   assign tq = src_tick && (pres_cnt_q == ctrl_q[can_init_pkg::CTRL_PRES_LSB +: 8]);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pres_cnt_q   <= 8'h00;
         quantum_tick <= 1'b0;
      end else begin
         quantum_tick <= tq;
         if (tq)
            pres_cnt_q <= 8'h00;
         else if (src_tick)
            pres_cnt_q <= pres_cnt_q + 8'h01;
      end
   end

   // Soft-reset request/acknowledge across the protocol side
   assign srst_fire = srst_req_q && a_s2_q && srst_pend_q;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         srst_pend_q <= 1'b0;
         srst_req_q  <= 1'b0;
         p_s1_q      <= 1'b0;
         p_s2_q      <= 1'b0;
         a_s1_q      <= 1'b0;
         a_s2_q      <= 1'b0;
      end else begin
         if (srst_fire)
            srst_pend_q <= 1'b0;
         else if (dev_soft_reset || (wr_mcr && wdata[can_init_pkg::MCR_SRST_BIT]))
            srst_pend_q <= 1'b1;
         srst_req_q <= srst_pend_q && !srst_fire && (srst_req_q || !a_s2_q);
         p_s1_q     <= srst_req_q;
         p_s2_q     <= p_s1_q;
         a_s1_q     <= p_s2_q;
         a_s2_q     <= a_s1_q;
      end
   end

   // Operating mode and module_config_reg bits
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q     <= can_init_pkg::MODE_DISABLED;
         dis_q      <= 1'b1;
         frz_q      <= 1'b1;
         hold_q     <= 1'b1;
         sync_cnt_q <= 4'h0;
      end else if (srst_fire) begin
         mode_q     <= dis_q ? can_init_pkg::MODE_DISABLED : can_init_pkg::MODE_FREEZE;
         frz_q      <= 1'b1;
         hold_q     <= 1'b1;
         sync_cnt_q <= 4'h0;
      end else begin
         if (wr_mcr) begin
            dis_q  <= wdata[can_init_pkg::MCR_DIS_BIT];
            frz_q  <= wdata[can_init_pkg::MCR_FRZ_BIT];
            hold_q <= wdata[can_init_pkg::MCR_HOLD_BIT];
         end
         unique case (mode_q)
            can_init_pkg::MODE_DISABLED: begin
               if (wr_mcr && !wdata[can_init_pkg::MCR_DIS_BIT]) begin
                  mode_q <= can_init_pkg::MODE_FREEZE;
                  frz_q  <= 1'b1;
                  hold_q <= 1'b1;
               end
            end
            can_init_pkg::MODE_FREEZE: begin
               sync_cnt_q <= 4'h0;
               if (wr_mcr && wdata[can_init_pkg::MCR_DIS_BIT])
                  mode_q <= can_init_pkg::MODE_DISABLED;
               else if (wr_mcr && !wdata[can_init_pkg::MCR_HOLD_BIT])
                  mode_q <= can_init_pkg::MODE_SYNCING;
               else if (wr_mcr) begin
                  frz_q  <= 1'b1;
                  hold_q <= 1'b1;
               end
            end
            can_init_pkg::MODE_SYNCING, can_init_pkg::MODE_ACTIVE: begin
               if (wr_mcr && wdata[can_init_pkg::MCR_DIS_BIT])
                  mode_q <= can_init_pkg::MODE_DISABLED;
               else if (wr_mcr && wdata[can_init_pkg::MCR_HOLD_BIT] && wdata[can_init_pkg::MCR_FRZ_BIT])
                  mode_q <= can_init_pkg::MODE_FREEZE;
               else if (mode_q == can_init_pkg::MODE_SYNCING && tq) begin
                  if (!rx_s2_q)
                     sync_cnt_q <= 4'h0;
                  else if (sync_cnt_q == can_init_pkg::SYNC_QUANTA - 4'h1)
                     mode_q <= can_init_pkg::MODE_ACTIVE;
                  else
                     sync_cnt_q <= sync_cnt_q + 4'h1;
               end
            end
         endcase
      end
   end

   // Bus side held recessive and quiet unless active
   assign frame_enable = (mode_q == can_init_pkg::MODE_ACTIVE);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         bus_transmit_pin <= 1'b1;
      else
         bus_transmit_pin <= frame_enable ? engine_tx : 1'b1;
   end

   // Configuration registers; clock source only changes while disabled
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q  <= can_init_pkg::CTRL_RESET;
         gmask_q <= can_init_pkg::WORD_ZERO;
         m14_q   <= can_init_pkg::WORD_ZERO;
         m15_q   <= can_init_pkg::WORD_ZERO;
         buffer_interrupt_mask_q <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wdata;
            if (mode_q != can_init_pkg::MODE_DISABLED)
               ctrl_q[can_init_pkg::CTRL_CSRC_BIT] <= ctrl_q[can_init_pkg::CTRL_CSRC_BIT];
         end
         if (wr_stb && hit(addr, can_init_pkg::GMASK_OFS))
            gmask_q <= wdata;
         if (wr_stb && hit(addr, can_init_pkg::M14_OFS))
            m14_q <= wdata;
         if (wr_stb && hit(addr, can_init_pkg::M15_OFS))
            m15_q <= wdata;
         if (wr_stb && hit(addr, can_init_pkg::BUFFER_INTERRUPT_MASK_OFS))
            buffer_interrupt_mask_q <= wdata[NUM_MB-1:0];
      end
   end

   // Sticky flags, write one to clear, set wins
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         buffer_interrupt_flags_q     <= '0;
         boff_flag_q <= 1'b0;
         err_flag_q  <= 1'b0;
      end else if (srst_fire) begin
         buffer_interrupt_flags_q     <= '0;
         boff_flag_q <= 1'b0;
         err_flag_q  <= 1'b0;
      end else begin
         if (wr_stb && hit(addr, can_init_pkg::BUFFER_INTERRUPT_FLAGS_OFS))
            buffer_interrupt_flags_q <= (buffer_interrupt_flags_q & ~wdata[NUM_MB-1:0]) | mb_event;
         else
            buffer_interrupt_flags_q <= buffer_interrupt_flags_q | mb_event;
         if (wr_stb && hit(addr, can_init_pkg::ESTAT_OFS)) begin
            boff_flag_q <= bus_off_event || (boff_flag_q && !wdata[can_init_pkg::ESTAT_BOFF_BIT]);
            err_flag_q  <= error_event || (err_flag_q && !wdata[can_init_pkg::ESTAT_ERR_BIT]);
         end else begin
            boff_flag_q <= boff_flag_q || bus_off_event;
            err_flag_q  <= err_flag_q || error_event;
         end
      end
   end

   // Interrupt outputs
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mb_irq      <= '0;
         mb_irq_any  <= 1'b0;
         bus_off_irq <= 1'b0;
         error_irq   <= 1'b0;
      end else begin
         mb_irq      <= buffer_interrupt_flags_q & buffer_interrupt_mask_q;
         mb_irq_any  <= |(buffer_interrupt_flags_q & buffer_interrupt_mask_q);
         bus_off_irq <= boff_flag_q && ctrl_q[can_init_pkg::CTRL_BOFF_MSK];
         error_irq   <= err_flag_q && ctrl_q[can_init_pkg::CTRL_ERR_MSK];
      end
   end

   // Message buffer words: no reset of any kind
   always_ff @(posedge sys_clk) begin
      if (wr_stb && addr[7:6] == can_init_pkg::MB_PAGE)
         mb_q[addr[5:2]] <= wdata;
   end

   // Read port, data in the following cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= can_init_pkg::WORD_ZERO;
      end else if (rd_stb) begin
         rdata <= can_init_pkg::WORD_ZERO;
         if (addr[7:6] == can_init_pkg::MB_PAGE)
            rdata <= mb_q[addr[5:2]];
         else if (hit(addr, can_init_pkg::MCR_OFS)) begin
            rdata[can_init_pkg::MCR_DIS_BIT]  <= dis_q;
            rdata[can_init_pkg::MCR_FRZ_BIT]  <= frz_q;
            rdata[can_init_pkg::MCR_HOLD_BIT] <= hold_q;
            rdata[can_init_pkg::MCR_NRDY_BIT] <= mode_q != can_init_pkg::MODE_ACTIVE;
            rdata[can_init_pkg::MCR_SRST_BIT] <= srst_pend_q;
            rdata[can_init_pkg::MCR_FACK_BIT] <= mode_q == can_init_pkg::MODE_FREEZE;
         end else if (hit(addr, can_init_pkg::CTRL_OFS))
            rdata <= ctrl_q;
         else if (hit(addr, can_init_pkg::BUFFER_INTERRUPT_MASK_OFS))
            rdata[NUM_MB-1:0] <= buffer_interrupt_mask_q;
         else if (hit(addr, can_init_pkg::BUFFER_INTERRUPT_FLAGS_OFS))
            rdata[NUM_MB-1:0] <= buffer_interrupt_flags_q;
         else if (hit(addr, can_init_pkg::ESTAT_OFS)) begin
            rdata[can_init_pkg::ESTAT_BOFF_BIT] <= boff_flag_q;
            rdata[can_init_pkg::ESTAT_ERR_BIT]  <= err_flag_q;
         end else if (hit(addr, can_init_pkg::GMASK_OFS))
            rdata <= gmask_q;
         else if (hit(addr, can_init_pkg::M14_OFS))
            rdata <= m14_q;
         else if (hit(addr, can_init_pkg::M15_OFS))
            rdata <= m15_q;
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence srst_write_s;
      wr_mcr && wdata[can_init_pkg::MCR_SRST_BIT] && !srst_pend_q;
   endsequence
   sequence frozen_s;
      mode_q == can_init_pkg::MODE_FREEZE && frz_q && hold_q;
   endsequence

   a_hard_reset_mode: assert property ($rose(resetn) |-> mode_q == can_init_pkg::MODE_DISABLED && dis_q)
      else $error("mode not disabled after hard reset");
   a_srst_pending: assert property (srst_write_s |=> srst_pend_q [*5])
      else $error("soft reset bit cleared too early");
   a_srst_bound: assert property ($rose(srst_pend_q) |-> ##[5:8] !srst_pend_q)
      else $error("soft reset did not complete in time");
   a_srst_effect: assert property (srst_fire |=> buffer_interrupt_flags_q == '0 && mode_q != can_init_pkg::MODE_ACTIVE && !srst_pend_q)
      else $error("soft reset did not clear state");
   a_freeze_entry: assert property (mode_q == can_init_pkg::MODE_DISABLED && wr_mcr
      && !wdata[can_init_pkg::MCR_DIS_BIT] && !srst_fire |=> frozen_s)
      else $error("no freeze after enabling");
   a_freeze_flags: assert property (mode_q == can_init_pkg::MODE_FREEZE |-> frz_q && hold_q)
      else $error("freeze without hold-off and freeze bits");
   a_freeze_quiet: assert property (mode_q != can_init_pkg::MODE_ACTIVE |-> !frame_enable ##1 bus_transmit_pin)
      else $error("bus driven outside active mode");
   a_hold_release: assert property (frozen_s ##0 wr_mcr && !wdata[can_init_pkg::MCR_HOLD_BIT]
      && !wdata[can_init_pkg::MCR_DIS_BIT] && !srst_fire |=> mode_q == can_init_pkg::MODE_SYNCING)
      else $error("hold-off clear did not start sync");
   a_sync_ready: assert property ($rose(mode_q == can_init_pkg::MODE_ACTIVE)
      |-> $past(sync_cnt_q) == can_init_pkg::SYNC_QUANTA - 4'h1)
      else $error("active before bus sync");
   a_mb_irq_path: assert property ((|(mb_event & buffer_interrupt_mask_q)) && !srst_fire && !wr_stb |=> ##1 mb_irq_any)
      else $error("buffer event gave no combined interrupt");
   a_err_gate: assert property (error_irq |-> $past(err_flag_q) && $past(ctrl_q[can_init_pkg::CTRL_ERR_MSK]))
      else $error("error interrupt without masked flag");
endmodule // can_init_reset_irq
`default_nettype wire

// ---- can_bus_node.sv ----
// Far-side CAN node: free-running crystal and a wired-AND bus line
`timescale 1ns/1ps
`default_nettype none
module can_bus_node #(
   parameter int XTAL_HALF_NS = 20
) (
   input  wire logic dut_tx,
   input  wire logic node_dominant,
   output logic      xtal_clk,
   output logic      bus_level
);
   // Crystal oscillates on its own, unrelated to the system clock
   initial begin
      xtal_clk = 1'b0;
      forever #(XTAL_HALF_NS) xtal_clk = ~xtal_clk;
   end
   // Bus is recessive unless some node pulls it dominant
   assign bus_level = dut_tx & ~node_dominant;
endmodule // can_bus_node
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the CAN start-up, soft-reset and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        sys_clk, resetn, wr_stb, rd_stb, dev_soft_reset, engine_tx;
   logic        bus_off_event, error_event, node_dominant, xtal, rx, tx, fe, css;
   logic        any, boff_irq, err_irq, qt;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [15:0] mb_event, mb_irq;
   int          fails, compares;
   // Crystal half period and its full period in 5 ns system clocks
   localparam int XTAL_HALF_NS  = 20;
   localparam int XTAL_TICK_CYC = 2 * XTAL_HALF_NS / 5;

   can_init_reset_irq can_init_reset_irq_i (.sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .dev_soft_reset(dev_soft_reset), .xtal_clk_pin(xtal),
      .bus_receive_pin(rx), .engine_tx(engine_tx), .mb_event(mb_event), .bus_off_event(bus_off_event),
      .error_event(error_event), .bus_transmit_pin(tx), .frame_enable(fe), .quantum_tick(qt),
      .clock_source_select(css), .mb_irq(mb_irq), .mb_irq_any(any), .bus_off_irq(boff_irq), .error_irq(err_irq));
   can_bus_node #(.XTAL_HALF_NS(XTAL_HALF_NS)) can_bus_node_i (.dut_tx(tx), .node_dominant(node_dominant),
      .xtal_clk(xtal), .bus_level(rx));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a; wdata <= d; wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      addr <= a; rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp, input string what);
      logic [31:0] v;
      rd(a, v);
      chk(v & msk, exp, what);
   endtask

   task automatic pulse(input logic [15:0] m, input logic b, input logic e);
      @(posedge sys_clk);
      mb_event <= m; bus_off_event <= b; error_event <= e;
      @(posedge sys_clk);
      mb_event <= 16'h0000; bus_off_event <= 1'b0; error_event <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   task automatic count_ticks(input int cyc, input int exp, input string what);
      int n;
      n = 0;
      repeat (cyc) begin
         @(posedge sys_clk);
         #1;
         if (qt === 1'b1)
            n++;
      end
      chk(n, exp, what);
   endtask

   task automatic soft_rst(input bit dev);
      logic [31:0] v;
      int          n;
      if (dev) begin
         @(posedge sys_clk);
         dev_soft_reset <= 1'b1;
         @(posedge sys_clk);
         dev_soft_reset <= 1'b0;
      end else begin
         wr(can_init_pkg::MCR_OFS, 32'h5200_0000);
      end
      rd(can_init_pkg::MCR_OFS, v);
      chk(v & 32'h0200_0000, 32'h0200_0000, "reset pending");
      n = 0;
      while (v[can_init_pkg::MCR_SRST_BIT] !== 1'b0 && n < 10) begin
         rd(can_init_pkg::MCR_OFS, v);
         n++;
      end
      chk(v & 32'h0200_0000, 32'h0, "reset done");
      chk(n, 3, "reset duration");
   endtask

   task automatic t_freeze();
      rdc(can_init_pkg::MCR_OFS, 32'hD000_0000, 32'hD000_0000, "reset mcr");
      chk({29'h0, tx, fe, css}, 32'h4, "reset pins");
      wr(can_init_pkg::CTRL_OFS, 32'h0000_2000);
      chk({31'h0, css}, 32'h1, "crystal select");
      count_ticks(10 * XTAL_TICK_CYC, 10, "crystal quanta");
      @(posedge sys_clk) engine_tx <= 1'b0;
      wr(can_init_pkg::MCR_OFS, 32'h5000_0000);
      rdc(can_init_pkg::MCR_OFS, 32'hD900_0000, 32'h5900_0000, "freeze mcr");
      chk({30'h0, tx, fe}, 32'h2, "freeze pins");
      wr(can_init_pkg::MCR_OFS, 32'h1000_0000);
      rdc(can_init_pkg::MCR_OFS, 32'hD900_0000, 32'h5900_0000, "freeze bits held");
      wr(can_init_pkg::CTRL_OFS, 32'h0000_C000);
      chk({31'h0, css}, 32'h1, "select locked");
      rdc(can_init_pkg::CTRL_OFS, 32'hFFFF_DFFF, 32'h0000_C000, "ctrl");
      for (int i = 0; i < 16; i++) begin
         wr(8'h80 + 8'(4 * i), {8'(i), 24'hC3_5A3C});
      end
      wr(can_init_pkg::GMASK_OFS, 32'h1FFF_FFFF);
      wr(can_init_pkg::M14_OFS, 32'h1FFF_0000);
      wr(can_init_pkg::M15_OFS, 32'h0000_FFFF);
      rdc(can_init_pkg::GMASK_OFS, 32'hFFFF_FFFF, 32'h1FFF_FFFF, "global mask");
      rdc(can_init_pkg::M14_OFS, 32'hFFFF_FFFF, 32'h1FFF_0000, "buffer14 mask");
      rdc(can_init_pkg::M15_OFS, 32'hFFFF_FFFF, 32'h0000_FFFF, "buffer15 mask");
   endtask

   task automatic t_irqs();
      logic [15:0] m;
      wr(can_init_pkg::BUFFER_INTERRUPT_MASK_OFS, 32'h0000_FFFF);
      for (int i = 0; i < 16; i++) begin
         m = 16'h0001 << i;
         pulse(m, 1'b0, 1'b0);
         chk({15'h0, any, mb_irq}, {15'h0, 1'b1, m}, "buffer irq");
         wr(can_init_pkg::BUFFER_INTERRUPT_FLAGS_OFS, {16'h0, m});
         repeat (2) @(posedge sys_clk);
         #1;
         chk({15'h0, any, mb_irq}, 32'h0, "irq cleared");
      end
      wr(can_init_pkg::BUFFER_INTERRUPT_MASK_OFS, 32'h0000_0008);
      pulse(16'h0028, 1'b1, 1'b1);
      chk({13'h0, boff_irq, err_irq, any, mb_irq}, 32'h0007_0008, "masked irqs");
      rdc(can_init_pkg::BUFFER_INTERRUPT_FLAGS_OFS, 32'h0000_FFFF, 32'h0000_0028, "flags");
      rdc(can_init_pkg::ESTAT_OFS, 32'h0000_0006, 32'h0000_0006, "estat");
      wr(can_init_pkg::CTRL_OFS, 32'h0000_4000);
      repeat (2) @(posedge sys_clk);
      #1;
      chk({30'h0, boff_irq, err_irq}, 32'h1, "bus-off masked");
   endtask

   task automatic t_soft();
      wr(8'h80, 32'hA5C3_5A3C);
      soft_rst(1'b0);
      rdc(can_init_pkg::BUFFER_INTERRUPT_FLAGS_OFS, 32'h0000_FFFF, 32'h0, "flags after soft");
      rdc(can_init_pkg::ESTAT_OFS, 32'h0000_0006, 32'h0, "estat after soft");
      rdc(can_init_pkg::CTRL_OFS, 32'hFFFF_DFFF, 32'h0000_4000, "ctrl kept");
      rdc(can_init_pkg::BUFFER_INTERRUPT_MASK_OFS, 32'h0000_FFFF, 32'h0000_0008, "buffer_interrupt_mask kept");
      rdc(can_init_pkg::GMASK_OFS, 32'hFFFF_FFFF, 32'h1FFF_FFFF, "mask kept");
      rdc(8'h80, 32'hFFFF_FFFF, 32'hA5C3_5A3C, "buffer kept");
      for (int i = 1; i < 16; i++) begin
         rdc(8'h80 + 8'(4 * i), 32'hFFFF_FFFF, {8'(i), 24'hC3_5A3C}, "buffer kept");
      end
      rdc(can_init_pkg::MCR_OFS, 32'hD900_0000, 32'h5900_0000, "still frozen");
      pulse(16'h0008, 1'b0, 1'b0);
      soft_rst(1'b1);
      rdc(can_init_pkg::BUFFER_INTERRUPT_FLAGS_OFS, 32'h0000_FFFF, 32'h0, "flags after device soft");
   endtask

   task automatic t_sync();
      int n;
      @(posedge sys_clk) node_dominant <= 1'b1;
      wr(can_init_pkg::MCR_OFS, 32'h0000_0000);
      repeat (200) @(posedge sys_clk);
      #1;
      chk({31'h0, fe}, 32'h0, "no sync on dominant bus");
      @(posedge sys_clk) node_dominant <= 1'b0;
      n = 0;
      while (fe !== 1'b1 && n < 400) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk({31'h0, fe}, 32'h1, "active");
      rdc(can_init_pkg::MCR_OFS, 32'h0900_0000, 32'h0, "ready");
      chk({31'h0, tx}, 32'h0, "engine drives tx");
      wr(can_init_pkg::MCR_OFS, 32'h5000_0000);
      repeat (2) @(posedge sys_clk);
      #1;
      chk({30'h0, tx, fe}, 32'h2, "refrozen pins");
   endtask

   task automatic t_hard();
      wr(can_init_pkg::MCR_OFS, 32'hD000_0000);
      rdc(can_init_pkg::MCR_OFS, 32'hD900_0000, 32'hD800_0000, "disabled mcr");
      wr(can_init_pkg::CTRL_OFS, 32'h0000_2000);
      chk({31'h0, css}, 32'h1, "select while disabled");
      @(posedge sys_clk) resetn <= 1'b0;
      #1;
      chk({30'h0, css, tx}, 32'h1, "async reset");
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      rdc(can_init_pkg::CTRL_OFS, 32'hFFFF_FFFF, can_init_pkg::CTRL_RESET, "ctrl reset");
      rdc(can_init_pkg::MCR_OFS, 32'hFFFF_FFFF, 32'hD800_0000, "mcr reset");
      rdc(8'h84, 32'hFFFF_FFFF, {8'h01, 24'hC3_5A3C}, "buffer after hard reset");
      wr(can_init_pkg::CTRL_OFS, 32'h0300_0000);
      count_ticks(40, 10, "bus clock quanta");
   endtask

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      end_sim();
   end

   initial begin
      fails = 0; compares = 0;
      resetn = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0; dev_soft_reset = 1'b0; engine_tx = 1'b1;
      bus_off_event = 1'b0; error_event = 1'b0; node_dominant = 1'b0;
      addr = 8'h00; wdata = 32'h0; mb_event = 16'h0000;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      t_freeze();
      t_irqs();
      t_soft();
      t_sync();
      t_hard();
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
